// ---- fpc_cpu_model.sv ----
// CPU core model: single-byte reads and writes of the flash control registers.
// Assumes strobes are taken on the rising edge of CORE_CLK.
`timescale 1ns/100ps
module fpc_cpu_model (
  input wire logic CORE_CLK,
  output logic [15:0] BUS_ADDR,
  output logic [7:0] BUS_WDATA,
  output logic BUS_RD,
  output logic BUS_WR,
  input wire logic [7:0] BUS_RDATA,
  input wire logic BUS_ACK
);
  initial begin
    BUS_ADDR = 16'h0000;
    BUS_WDATA = 8'h00;
    BUS_RD = 1'b0;
    BUS_WR = 1'b0;
  end
  // Byte access, answer taken one state after the strobe; released lines show inverted values
  task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] data, output logic [7:0] rd,
    output logic ack);
    @(negedge CORE_CLK);
    BUS_ADDR = addr;
    BUS_WDATA = data;
    BUS_WR = wr;
    BUS_RD = !wr;
    @(negedge CORE_CLK);
    ack = BUS_ACK;
    rd = BUS_RDATA;
    BUS_WR = 1'b0;
    BUS_RD = 1'b0;
    BUS_ADDR = ~addr;
    BUS_WDATA = ~data;
  endtask
endmodule

// ---- fpc_fault_check.sv ----
// Fault watcher for program and erase operations.
// Assumes the array reports faults and unit starts synchronous to CORE_CLK.
`timescale 1ns/100ps
module fpc_fault_check (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic prog_active,
  input wire logic erase_active,
  input wire logic array_fault,
  input wire logic unit_start,
  input wire logic [15:0] unit_addr,
  output logic fault
);
  import fpc_pkg::*;

  typedef struct packed {
    logic fault;
  } fpc_fault_state_t;

  fpc_fault_state_t state;
  fpc_fault_state_t next_state;
  logic misaligned;

  always_comb begin
    next_state = state;
    // A unit must start on a 128-byte boundary inside the array
    misaligned = unit_start && prog_active &&
      ((unit_addr[FPC_UNIT_LSB-1:0] != '0) || (unit_addr > FPC_ARRAY_END));
    // Sticky until reset; the array stays protected once a fault is seen
    if (((prog_active || erase_active) && array_fault) || misaligned) begin
      next_state.fault = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state.fault <= FPC_RST_ERROR[FPC_BIT_FAULT];
    end else begin
      state <= next_state;
    end
  end

  assign fault = state.fault;
endmodule

// ---- fpc_flash_control.sv ----
// Flash program/erase control registers and mode sequencing.
// Assumes a CPU byte bus with one-cycle read/write strobes, synchronous to CORE_CLK.
//
// Behaviour
// - Array splits into four 1K, one 28K, 16K, 8K, 4K erase blocks.
// - Programming uses 128-byte units starting at low byte 00 or 80.
// - All registers are byte wide, byte access only, two-state access.
// - Mode-control writes select program, program-verify, erase or erase-verify.
// - Mode-control top bit reads zero, writes to it ignored.
// - Write gate zero blocks program/erase and setting other mode or block bits.
// - Write gate one permits program/erase and setting other control bits.
// - Erase-setup bit enters erase setup state, clears to cancel, resets zero.
// - All five registers reset to 00.
// - Erase mode only when gate and erase-setup already one.
// - Program mode only when gate and program-setup already one.
// - Read-only fault flag sets on program or erase fault.
`timescale 1ns/100ps
module fpc_flash_control (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  output logic [7:0] BUS_RDATA,
  output logic BUS_ACK,
  input wire logic ARRAY_FAULT,
  input wire logic UNIT_START,
  input wire logic [15:0] UNIT_ADDR,
  output logic PROGRAM_MODE,
  output logic PROGRAM_VERIFY_MODE,
  output logic ERASE_MODE,
  output logic ERASE_VERIFY_MODE,
  output logic ERASE_SETUP_STATE,
  output logic PROGRAM_SETUP_STATE,
  output logic [fpc_pkg::FPC_NUM_BLOCKS-1:0] ERASE_BLOCK_EN,
  output logic POWER_DOWN_DISABLE,
  output logic FAULT_FLAG
);
  import fpc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] eblock;
    logic pdwnd;
    logic ctrl_en;
    logic [7:0] rdata;
    logic ack;
    logic prog;
    logic erase;
  } fpc_state_t;

  fpc_state_t state;
  fpc_state_t next_state;
  logic fault;
  logic access;
  logic gated;
  logic [7:0] wmode;
  logic [7:0] rd_value;

  // ****************************************
  // Fault watcher
  // ****************************************
  fpc_fault_check u_fault (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .prog_active(state.prog),
    .erase_active(state.erase),
    .array_fault(ARRAY_FAULT),
    .unit_start(UNIT_START),
    .unit_addr(UNIT_ADDR),
    .fault(fault)
  );

  // ****************************************
  // Register access and mode logic
  // ****************************************
  always_comb begin
    next_state = state;
    access = BUS_RD || BUS_WR;
    // The enable register itself is always reachable; the rest only behind it
    gated = state.ctrl_en || (BUS_ADDR == FPC_ADDR_ENABLE);
    wmode = state.mode;
    rd_value = 8'h00;

    // Answer lands one state after the strobe, so every access spans two states
    next_state.ack = access;
    next_state.rdata = 8'h00;

    if (BUS_RD && gated) begin
      unique case (BUS_ADDR)
        FPC_ADDR_MODE: rd_value = {1'b0, state.mode[FPC_BIT_SWE:0]};
        FPC_ADDR_ERROR: rd_value = {fault, 7'h00};
        FPC_ADDR_POWER: rd_value = {state.pdwnd, 7'h00};
        FPC_ADDR_EBLOCK: rd_value = state.eblock;
        FPC_ADDR_ENABLE: rd_value = {state.ctrl_en, 7'h00};
        default: rd_value = 8'h00;
      endcase
      next_state.rdata = rd_value;
    end

    if (BUS_WR && gated) begin
      unique case (BUS_ADDR)
        FPC_ADDR_MODE: begin
          wmode = BUS_WDATA;
          wmode[FPC_BIT_RSVD] = 1'b0;
          if (!state.mode[FPC_BIT_SWE]) begin
            // Gate was closed: only the gate itself may be set this write
            wmode[FPC_BIT_ESU:0] = '0;
          end
          if (!(state.mode[FPC_BIT_SWE] && state.mode[FPC_BIT_ESU])) begin
            wmode[FPC_BIT_E] = 1'b0;
          end
          if (!(state.mode[FPC_BIT_SWE] && state.mode[FPC_BIT_PSU])) begin
            wmode[FPC_BIT_P] = 1'b0;
          end
          next_state.mode = wmode;
        end
        FPC_ADDR_POWER: next_state.pdwnd = BUS_WDATA[FPC_BIT_PDWND];
        FPC_ADDR_EBLOCK: begin
          // Refused with the gate shut; more than one bit clears the lot
          if (state.mode[FPC_BIT_SWE] && ($countones(BUS_WDATA) <= 1)) begin
            next_state.eblock = BUS_WDATA;
          end else begin
            next_state.eblock = 8'h00;
          end
        end
        FPC_ADDR_ENABLE: next_state.ctrl_en = BUS_WDATA[FPC_BIT_CTRL_EN];
        default: begin
        end
      endcase
    end

    // Block selects only live while the write gate is open
    if (!next_state.mode[FPC_BIT_SWE]) begin
      next_state.eblock = 8'h00;
    end

    // Error protection drops the active operation; the fault stays sticky
    next_state.prog = next_state.mode[FPC_BIT_SWE] && next_state.mode[FPC_BIT_P] && !fault;
    next_state.erase = next_state.mode[FPC_BIT_SWE] && next_state.mode[FPC_BIT_E] && !fault;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state.mode <= FPC_RST_MODE;
      state.eblock <= FPC_RST_EBLOCK;
      state.pdwnd <= FPC_RST_POWER[FPC_BIT_PDWND];
      state.ctrl_en <= FPC_RST_ENABLE[FPC_BIT_CTRL_EN];
      state.rdata <= 8'h00;
      state.ack <= 1'b0;
      state.prog <= 1'b0;
      state.erase <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign BUS_RDATA = state.rdata;
  assign BUS_ACK = state.ack;
  assign PROGRAM_MODE = state.prog;
  assign ERASE_MODE = state.erase;
  assign PROGRAM_VERIFY_MODE = state.mode[FPC_BIT_PV];
  assign ERASE_VERIFY_MODE = state.mode[FPC_BIT_EV];
  assign ERASE_SETUP_STATE = state.mode[FPC_BIT_ESU];
  assign PROGRAM_SETUP_STATE = state.mode[FPC_BIT_PSU];
  assign ERASE_BLOCK_EN = state.eblock;
  assign POWER_DOWN_DISABLE = state.pdwnd;
  assign FAULT_FLAG = fault;
endmodule

// ---- fpc_flash_control_properties.sv ----
// Checker for the flash control block: bus answer, mode entry, fault handling.
// Assumes it sees only the top ports; bound below.
`timescale 1ns/100ps
module fpc_flash_control_properties (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [15:0] BUS_ADDR,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic [7:0] BUS_RDATA,
  input wire logic BUS_ACK,
  input wire logic ARRAY_FAULT,
  input wire logic UNIT_START,
  input wire logic PROGRAM_MODE,
  input wire logic ERASE_MODE,
  input wire logic ERASE_SETUP_STATE,
  input wire logic PROGRAM_SETUP_STATE,
  input wire logic [7:0] ERASE_BLOCK_EN,
  input wire logic FAULT_FLAG
);
  import fpc_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // ****************************************
  // Sequences
  // ****************************************
  sequence s_access;
    BUS_RD || BUS_WR;
  endsequence
  sequence s_answer;
    ##1 BUS_ACK;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_ack_follows: assert property (s_access |-> s_answer) else $error("no ack after strobe");
  a_ack_cause: assert property (BUS_ACK |-> $past(BUS_RD || BUS_WR)) else $error("ack without strobe");
  a_mode_top_zero: assert property (BUS_ACK && $past(BUS_RD && BUS_ADDR == FPC_ADDR_MODE) |-> !BUS_RDATA[7])
    else $error("mode top bit read as one");
  a_erase_setup_first: assert property ($rose(ERASE_MODE) |-> $past(ERASE_SETUP_STATE)) else $error("erase without setup");
  a_prog_setup_first: assert property ($rose(PROGRAM_MODE) |-> $past(PROGRAM_SETUP_STATE)) else $error("program without setup");
  a_block_single: assert property ($onehot0(ERASE_BLOCK_EN)) else $error("several erase blocks");
  // Reset checking must not be disabled by the reset itself
  a_reset_clear: assert property (disable iff (1'b0) !RST_B |=> !ERASE_BLOCK_EN && !FAULT_FLAG && !ERASE_MODE)
    else $error("outputs not cleared by reset");
  a_fault_sticky: assert property (FAULT_FLAG |=> FAULT_FLAG) else $error("fault flag dropped");
  a_fault_halts: assert property (FAULT_FLAG |=> !PROGRAM_MODE && !ERASE_MODE) else $error("mode kept after fault");
  a_fault_cause: assert property ($rose(FAULT_FLAG) |-> $past(PROGRAM_MODE || ERASE_MODE) && $past(ARRAY_FAULT || UNIT_START))
    else $error("fault flag without cause");
endmodule
bind fpc_flash_control fpc_flash_control_properties u_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .BUS_ADDR(BUS_ADDR),
  .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_RDATA(BUS_RDATA), .BUS_ACK(BUS_ACK), .ARRAY_FAULT(ARRAY_FAULT),
  .UNIT_START(UNIT_START), .PROGRAM_MODE(PROGRAM_MODE), .ERASE_MODE(ERASE_MODE), .ERASE_SETUP_STATE(ERASE_SETUP_STATE),
  .PROGRAM_SETUP_STATE(PROGRAM_SETUP_STATE), .ERASE_BLOCK_EN(ERASE_BLOCK_EN), .FAULT_FLAG(FAULT_FLAG));

// ---- fpc_pkg.sv ----
// Constants for the flash program/erase control block.
// Assumes a 16-bit CPU byte address space with the control registers near the top.
package fpc_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] FPC_ADDR_MODE = 16'hF020;
  localparam logic [15:0] FPC_ADDR_ERROR = 16'hF021;
  localparam logic [15:0] FPC_ADDR_POWER = 16'hF022;
  localparam logic [15:0] FPC_ADDR_EBLOCK = 16'hF023;
  localparam logic [15:0] FPC_ADDR_ENABLE = 16'hF02B;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] FPC_RST_MODE = 8'h00;
  localparam logic [7:0] FPC_RST_ERROR = 8'h00;
  localparam logic [7:0] FPC_RST_POWER = 8'h00;
  localparam logic [7:0] FPC_RST_EBLOCK = 8'h00;
  localparam logic [7:0] FPC_RST_ENABLE = 8'h00;

  // ****************************************
  // Mode-control field positions
  // ****************************************
  localparam int FPC_BIT_RSVD = 7;
  localparam int FPC_BIT_SWE = 6;
  localparam int FPC_BIT_ESU = 5;
  localparam int FPC_BIT_PSU = 4;
  localparam int FPC_BIT_EV = 3;
  localparam int FPC_BIT_PV = 2;
  localparam int FPC_BIT_E = 1;
  localparam int FPC_BIT_P = 0;

  // Single-bit fields of the other registers
  localparam int FPC_BIT_FAULT = 7;
  localparam int FPC_BIT_PDWND = 7;
  localparam int FPC_BIT_CTRL_EN = 7;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int FPC_NUM_BLOCKS = 8;
  localparam int FPC_BLOCK_1K = 1024;
  localparam int FPC_BLOCK_28K = 28672;
  localparam int FPC_BLOCK_16K = 16384;
  localparam int FPC_BLOCK_8K = 8192;
  localparam int FPC_BLOCK_4K = 4096;
  localparam int FPC_UNIT_BYTES = 128;
  localparam int FPC_UNIT_LSB = 7;
  localparam logic [15:0] FPC_ARRAY_END = 16'hEFFF;

  // Access time in bus states
  localparam int FPC_ACCESS_STATES = 2;

endpackage

// ---- tb_top.sv ----
// Testbench for the flash control block.
// Assumes the CPU model drives the bus and the bench drives the array side.
`timescale 1ns/100ps
module tb_top;
  import fpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic array_fault = 1'b0;
  logic unit_start = 1'b0;
  logic [15:0] unit_addr = 16'h0000;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, blk;
  logic bus_rd, bus_wr, bus_ack, pm, pvm, em, evm, ess, pss, pdd, flt;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 core_clk = ~core_clk;
  fpc_cpu_model u_cpu (.CORE_CLK(core_clk), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_RD(bus_rd),
    .BUS_WR(bus_wr), .BUS_RDATA(bus_rdata), .BUS_ACK(bus_ack));
  fpc_flash_control u_dut (.CORE_CLK(core_clk), .RST_B(rst_b), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
    .BUS_RD(bus_rd), .BUS_WR(bus_wr), .BUS_RDATA(bus_rdata), .BUS_ACK(bus_ack), .ARRAY_FAULT(array_fault),
    .UNIT_START(unit_start), .UNIT_ADDR(unit_addr), .PROGRAM_MODE(pm), .PROGRAM_VERIFY_MODE(pvm), .ERASE_MODE(em),
    .ERASE_VERIFY_MODE(evm), .ERASE_SETUP_STATE(ess), .PROGRAM_SETUP_STATE(pss), .ERASE_BLOCK_EN(blk),
    .POWER_DOWN_DISABLE(pdd), .FAULT_FLAG(flt));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    u_cpu.access(w, a, d, r, k);
    chk({7'h00, k}, 8'h01);
    if (!w) chk(r, d);
  endtask
  task automatic do_reset();
    @(negedge core_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
  endtask
  task automatic t_regs();
    acc(0, FPC_ADDR_ENABLE, 8'h00);
    acc(1, FPC_ADDR_ENABLE, 8'h80);
    for (int i = 0; i < 4; i++) acc(0, FPC_ADDR_MODE + 16'(i), 8'h00);
    acc(1, FPC_ADDR_MODE, 8'h3F);
    acc(0, FPC_ADDR_MODE, 8'h00);
    acc(1, FPC_ADDR_MODE, 8'hC0);
    acc(0, FPC_ADDR_MODE, 8'h40);
    for (int i = 0; i < 8; i++) begin
      acc(1, FPC_ADDR_EBLOCK, 8'h01 << i);
      chk(blk, 8'h01 << i);
    end
    acc(1, FPC_ADDR_EBLOCK, 8'h03);
    acc(0, FPC_ADDR_EBLOCK, 8'h00);
    acc(1, FPC_ADDR_ERROR, 8'hFF);
    acc(0, FPC_ADDR_ERROR, 8'h00);
    acc(1, FPC_ADDR_POWER, 8'h80);
    chk({7'h00, pdd}, 8'h01);
    $display("t_regs done");
  endtask
  task automatic t_erase();
    acc(1, FPC_ADDR_MODE, 8'h42);
    chk({7'h00, em}, 8'h00);
    acc(1, FPC_ADDR_MODE, 8'h60);
    chk({6'h00, ess, em}, 8'h02);
    acc(1, FPC_ADDR_MODE, 8'h62);
    chk({7'h00, em}, 8'h01);
    acc(1, FPC_ADDR_MODE, 8'h48);
    chk({5'h00, em, evm, ess}, 8'h02);
    acc(1, FPC_ADDR_MODE, 8'h44);
    chk({6'h00, pvm, evm}, 8'h02);
    acc(1, FPC_ADDR_MODE, 8'h60);
    acc(1, FPC_ADDR_MODE, 8'h62);
    array_fault = 1'b1;
    @(negedge core_clk);
    array_fault = 1'b0;
    chk({7'h00, flt}, 8'h01);
    @(negedge core_clk);
    chk({7'h00, em}, 8'h00);
    acc(0, FPC_ADDR_ERROR, 8'h80);
    $display("t_erase done");
  endtask
  task automatic t_program();
    acc(1, FPC_ADDR_ENABLE, 8'h80);
    acc(1, FPC_ADDR_MODE, 8'h40);
    acc(1, FPC_ADDR_MODE, 8'h50);
    acc(1, FPC_ADDR_MODE, 8'h51);
    chk({6'h00, pss, pm}, 8'h03);
    // Aligned start first: the fault flag is sticky, so the misaligned one must come last
    for (int i = 0; i < 2; i++) begin
      unit_addr = i ? 16'h0081 : 16'h0080;
      unit_start = 1'b1;
      @(negedge core_clk);
      unit_start = 1'b0;
      unit_addr = 16'hFFFF;
      chk({7'h00, flt}, 8'(i));
    end
    @(negedge core_clk);
    chk({7'h00, pm}, 8'h00);
    acc(1, FPC_ADDR_MODE, 8'h00);
    acc(0, FPC_ADDR_MODE, 8'h00);
    $display("t_program done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the fewer than a hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    do_reset();
    t_regs();
    t_erase();
    do_reset();
    t_program();
    conclude();
  end
endmodule
